/* File: design/ews_top.sv */
// serial front end of the three-wire eeprom, with the write engine below it
// Notes on behaviour
// - act on serial traffic only while select is high.
// - deselected: ignore serial input, serial output not driven.
// - sample instruction, address and data on each shift clock rising edge.
// - change the read data output only on a shift clock rising edge; ready/busy follows busy.
// - read command decodes the address and shifts that word out.
// - after a write started, a long deselect then select shows ready/busy.
// - strap high gives 16-bit words, strap low 8-bit words.
// - a floating strap reads high, so 16-bit is the default.
// - array holds 256 words of 16 bits or 512 of 8.
// - writes run on internal timing, no separate erase needed.
// - an internal write cycle ends within 5 ms.
// - writes start only when erase/write is unlocked.
`timescale 1ns/1ps
module ews_top #(
  parameter int WRITE_CYC = ews_pkg::WRITE_CYC,
  parameter int MEM_BYTES = ews_pkg::MEM_BYTES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial pins
  input wire logic select_in,
  input wire logic shift_clock,
  input wire logic serial_in,
  output logic     serial_out,
  output logic     serial_out_oe,
  // organisation strap
  input wire logic word_width_strap
);
  typedef struct packed {
    logic [1:0]             cs_sync;
    logic [2:0]             sk_sync;
    logic [1:0]             di_sync;
    logic [1:0]             org_sync;
    logic                   cs_d;
    ews_pkg::ews_state_e    st;
    logic [4:0]             cnt;
    logic [10:0]            cmd;
    logic [15:0]            sr;
    logic [8:0]             addr;
    ews_pkg::ews_kind_e     kind;
    logic                   unlock;
    logic                   pend;
    logic [4:0]             desel;
    logic                   x16;
    logic                   out;
    logic                   oe;
    logic                   start;
  } ews_top_s;

  localparam logic [4:0] DESEL_MIN = 5'(ews_pkg::MIN_DESEL_CYC);

  ews_top_s r;
  ews_top_s n;
  ews_eng_if eif ();

  logic       cs_on;
  logic       sk_rise;
  logic       di;
  logic [10:0] cmd_n;
  logic [1:0] op;
  logic [8:0] a;
  logic [3:0] bit_sel;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [4:0] word_bits(input logic x16);
    return x16 ? 5'(ews_pkg::WORD_X16) : 5'(ews_pkg::WORD_X8);
  endfunction

  function automatic logic [4:0] cmd_last(input logic x16);
    return x16 ? 5'(ews_pkg::ADDR_X16 + 1) : 5'(ews_pkg::ADDR_X8 + 1);
  endfunction

  function automatic logic [1:0] op_of(input logic [10:0] c, input logic x16);
    return x16 ? c[9:8] : c[10:9];
  endfunction

  function automatic logic [8:0] addr_of(input logic [10:0] c, input logic x16);
    return x16 ? {1'h0, c[7:0]} : c[8:0];
  endfunction

  function automatic logic [1:0] ext_of(input logic [8:0] ad, input logic x16);
    return x16 ? ad[7:6] : ad[8:7];
  endfunction

  // first sync stage feeds only the second
  assign cs_on   = r.cs_sync[1];
  assign sk_rise = r.sk_sync[1] && !r.sk_sync[2];
  assign di      = r.di_sync[1];
  assign cmd_n   = {r.cmd[9:0], di};
  assign op      = op_of(cmd_n, r.x16);
  assign a       = addr_of(cmd_n, r.x16);
  assign bit_sel = 4'(word_bits(r.x16) - 5'h01 - r.cnt);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    n          = r;
    n.cs_sync  = {r.cs_sync[0], select_in};
    n.sk_sync  = {r.sk_sync[1:0], shift_clock};
    n.di_sync  = {r.di_sync[0], serial_in};
    n.org_sync = {r.org_sync[0], word_width_strap};
    n.cs_d     = r.cs_sync[1];
    n.start    = 1'h0;
    if (!cs_on) begin
      // strap is static; re-read only while deselected so a word never changes width mid-frame
      n.x16 = r.org_sync[1];
      if (r.desel != DESEL_MIN) begin
        n.desel = r.desel + 5'h01;
      end
      // command commits on the falling select
      if (r.st == ews_pkg::ST_WAIT && r.kind != ews_pkg::K_NONE && r.unlock && !eif.busy) begin
        n.start = 1'h1;
        n.pend  = 1'h1;
      end else begin
        // kind held one more cycle: engine reads fill data and sweep from it with the start
        n.kind = ews_pkg::K_NONE;
      end
      n.st   = ews_pkg::ST_IDLE;
      n.oe   = 1'h0;
      n.out  = 1'h0;
    end else if (!r.cs_d) begin
      // select just returned
      if (r.pend && r.desel == DESEL_MIN) begin
        n.st  = ews_pkg::ST_STATUS;
        n.oe  = 1'h1;
        n.out = !eif.busy;
      end
      n.desel = '0;
    end else begin
      case (r.st)
        ews_pkg::ST_IDLE: begin
          if (sk_rise && di) begin
            n.st  = ews_pkg::ST_CMD;
            n.cnt = '0;
            n.cmd = '0;
          end
        end
        ews_pkg::ST_CMD: begin
          if (sk_rise) begin
            n.cmd = cmd_n;
            n.cnt = r.cnt + 5'h01;
            if (r.cnt == cmd_last(r.x16)) begin
              n.addr = a;
              n.cnt  = '0;
              n.kind = ews_pkg::K_NONE;
              n.st   = ews_pkg::ST_WAIT;
              case (op)
                ews_pkg::OP_READ: begin
                  // dummy zero precedes the word
                  n.st  = ews_pkg::ST_READ_OUT;
                  n.oe  = 1'h1;
                  n.out = 1'h0;
                end
                ews_pkg::OP_WRITE: begin
                  n.st   = ews_pkg::ST_DATA_IN;
                  n.kind = ews_pkg::K_WRITE;
                end
                ews_pkg::OP_ERASE: begin
                  n.kind = ews_pkg::K_ERASE;
                end
                default: begin
                  case (ext_of(a, r.x16))
                    ews_pkg::EXT_ERASE_WRITE_UNLOCK: begin
                      n.unlock = 1'h1;
                    end
                    ews_pkg::EXT_LOCK: begin
                      n.unlock = 1'h0;
                    end
                    ews_pkg::EXT_WRAL: begin
                      n.st   = ews_pkg::ST_DATA_IN;
                      n.kind = ews_pkg::K_WRAL;
                    end
                    default: begin
                      n.kind = ews_pkg::K_ERAL;
                    end
                  endcase
                end
              endcase
            end
          end
        end
        ews_pkg::ST_DATA_IN: begin
          if (sk_rise) begin
            n.sr  = {r.sr[14:0], di};
            n.cnt = r.cnt + 5'h01;
            if (r.cnt == word_bits(r.x16) - 5'h01) begin
              n.st = ews_pkg::ST_WAIT;
            end
          end
        end
        ews_pkg::ST_READ_OUT: begin
          // keeps clocking out following words until deselected
          if (sk_rise) begin
            n.out = eif.rd_data[bit_sel];
            n.cnt = r.cnt + 5'h01;
            if (r.cnt == word_bits(r.x16) - 5'h01) begin
              n.cnt  = '0;
              n.addr = r.addr + 9'h001;
            end
          end
        end
        ews_pkg::ST_WAIT: begin
          n.st = ews_pkg::ST_WAIT;
        end
        ews_pkg::ST_STATUS: begin
          n.out = !eif.busy;
          if (sk_rise && di) begin
            n.st   = ews_pkg::ST_CMD;
            n.cnt  = '0;
            n.cmd  = '0;
            n.oe   = 1'h0;
            n.pend = 1'h0;
          end
        end
        default: begin
          n.st = ews_pkg::ST_IDLE;
        end
      endcase
    end
    if (!resetn) begin
      n      = '0;
      n.st   = ews_pkg::ST_IDLE;
      n.kind = ews_pkg::K_NONE;
      n.x16  = ews_pkg::X16_RESET;
    end
  end

  always_ff @(posedge clk) begin
    r <= n;
  end

  // ************************************************************
  // engine hookup
  // ************************************************************
  assign eif.start   = r.start;
  assign eif.all     = (r.kind == ews_pkg::K_WRAL) || (r.kind == ews_pkg::K_ERAL);
  assign eif.x16     = r.x16;
  assign eif.addr    = r.addr;
  assign eif.rd_addr = r.addr;
  // erase needs no pre-erase pass: it is just a write of all ones
  assign eif.data    = (r.kind == ews_pkg::K_ERASE || r.kind == ews_pkg::K_ERAL) ?
                       ews_pkg::ERASED_WORD : r.sr;

  ews_engine #(
    .WRITE_CYC (WRITE_CYC),
    .MEM_BYTES (MEM_BYTES)
  ) u_engine (
    .clk    (clk),
    .resetn (resetn),
    .eif    (eif.eng)
  );

  assign serial_out    = r.out;
  assign serial_out_oe = r.oe;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_long_low;
    !r.cs_sync[1] && r.desel == DESEL_MIN;
  endsequence

  sequence s_reselect;
    r.cs_sync[1] && r.pend;
  endsequence

  a_desel_idle: assert property (
    !r.cs_sync[1] |=> r.st == ews_pkg::ST_IDLE)
    else $error("state active while deselected");
  a_desel_hiz: assert property (
    !r.cs_sync[1] |=> !serial_out_oe)
    else $error("output driven while deselected");
  a_sample_edge: assert property (
    ($changed(r.sr) || $changed(r.cmd)) && r.cs_d && r.cs_sync[1] |-> $past(sk_rise))
    else $error("input sampled off the shift clock edge");
  a_out_edge: assert property (
    (r.st == ews_pkg::ST_READ_OUT && $changed(serial_out)) |-> $past(sk_rise))
    else $error("read output changed off the shift clock edge");
  a_read_dummy: assert property (
    $rose(r.st == ews_pkg::ST_READ_OUT) |-> serial_out_oe && !serial_out)
    else $error("read did not start with a driven zero");
  a_status_show: assert property (
    s_long_low ##1 s_reselect |=> serial_out_oe && serial_out == !$past(eif.busy))
    else $error("ready/busy not shown after long deselect");
  a_status_busy: assert property (
    (r.st == ews_pkg::ST_STATUS && eif.busy) |=> !serial_out)
    else $error("status high while write in progress");
  a_strap_follow: assert property (
    !r.cs_sync[1] |=> r.x16 == $past(r.org_sync[1]))
    else $error("organisation does not follow the strap");
  a_strap_default: assert property (disable iff (1'h0)
    !resetn |=> r.x16)
    else $error("organisation not 16-bit after reset");
  a_lock_gate: assert property (
    r.start |-> $past(r.unlock))
    else $error("write started while locked");
endmodule

/* File: design/ews_pkg.sv */
// shared constants and types for the three-wire serial eeprom port
package ews_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS        = 10;
  localparam int MIN_DESELECT_TIME_NS = 250;
  // least time: round up
  localparam int MIN_DESEL_CYC =
    (MIN_DESELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_TIME_MS = 5;
  // longest time: round down
  localparam int WRITE_CYC = (WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;

  // ************************************************************
  // organisation
  // ************************************************************
  localparam int MEM_BYTES = 512;
  localparam int ADDR_X16  = 8;
  localparam int ADDR_X8   = 9;
  localparam int WORD_X16  = 16;
  localparam int WORD_X8   = 8;
  localparam logic X16_RESET = 1'h1;
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // ************************************************************
  // command codes
  // ************************************************************
  localparam logic [1:0] OP_EXT   = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] EXT_LOCK = 2'h0;
  localparam logic [1:0] EXT_WRAL = 2'h1;
  localparam logic [1:0] EXT_ERAL = 2'h2;
  localparam logic [1:0] EXT_ERASE_WRITE_UNLOCK = 2'h3;

  typedef enum logic [2:0] {
    K_NONE  = 3'h0,
    K_WRITE = 3'h1,
    K_ERASE = 3'h2,
    K_WRAL  = 3'h3,
    K_ERAL  = 3'h4
  } ews_kind_e;

  typedef enum logic [5:0] {
    ST_IDLE     = 6'h01,
    ST_CMD      = 6'h02,
    ST_DATA_IN  = 6'h04,
    ST_READ_OUT = 6'h08,
    ST_WAIT     = 6'h10,
    ST_STATUS   = 6'h20
  } ews_state_e;
endpackage

/* File: design/ews_eng_if.sv */
// link between the serial front end and the self-timed write engine
`timescale 1ns/1ps
interface ews_eng_if;
  logic        start;
  logic        all;
  logic        x16;
  logic [8:0]  addr;
  logic [15:0] data;
  logic        busy;
  logic [8:0]  rd_addr;
  logic [15:0] rd_data;

  modport ctl (output start, all, x16, addr, data, rd_addr, input busy, rd_data);
  modport eng (input start, all, x16, addr, data, rd_addr, output busy, rd_data);
endinterface

/* File: design/ews_engine.sv */
// memory array and self-timed write engine
`timescale 1ns/1ps
module ews_engine #(
  parameter int WRITE_CYC = ews_pkg::WRITE_CYC,
  parameter int MEM_BYTES = ews_pkg::MEM_BYTES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // front end
  ews_eng_if.eng   eif
);
  localparam int TW = $clog2(WRITE_CYC + 1);
  localparam int BW = $clog2(MEM_BYTES);

  typedef struct packed {
    logic [TW-1:0] timer;
    logic          sweep;
    logic [BW-1:0] ptr;
    logic [15:0]   data;
    logic          x16;
  } ews_eng_s;

  ews_eng_s   eng_r;
  ews_eng_s   eng_nxt;
  logic [7:0] mem [MEM_BYTES];
  logic       we_one;
  logic       we_sweep;
  logic [BW-1:0] rd_idx;
  logic [BW-1:0] wr_idx;

  // x16 words take two bytes, high byte first
  function automatic logic [BW-1:0] byte_index(input logic [8:0] a, input logic x16);
    return x16 ? BW'({a, 1'h0}) : BW'(a);
  endfunction

  // ************************************************************
  // write sequencing
  // ************************************************************
  always_comb begin
    eng_nxt  = eng_r;
    we_one   = 1'h0;
    we_sweep = eng_r.sweep;
    wr_idx   = byte_index(eif.addr, eif.x16);
    if (eng_r.timer != '0) begin
      eng_nxt.timer = eng_r.timer - 1'h1;
    end
    if (eng_r.sweep) begin
      eng_nxt.ptr = eng_r.ptr + 1'h1;
      if (eng_r.ptr == BW'(MEM_BYTES - 1)) begin
        eng_nxt.sweep = 1'h0;
      end
    end
    // a start while busy is dropped; the front end never sends one
    if (eif.start && eng_r.timer == '0) begin
      eng_nxt.timer = TW'(WRITE_CYC);
      eng_nxt.data  = eif.data;
      eng_nxt.x16   = eif.x16;
      eng_nxt.sweep = eif.all;
      eng_nxt.ptr   = '0;
      we_one        = !eif.all;
    end
    if (!resetn) begin
      eng_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    eng_r <= eng_nxt;
  end

  // array keeps no reset: it is the stored contents
  always_ff @(posedge clk) begin
    if (we_one) begin
      mem[wr_idx] <= eif.x16 ? eif.data[15:8] : eif.data[7:0];
      if (eif.x16) begin
        mem[BW'(wr_idx + 1'h1)] <= eif.data[7:0];
      end
    end else if (we_sweep) begin
      mem[eng_r.ptr] <= (eng_r.x16 && !eng_r.ptr[0]) ? eng_r.data[15:8] : eng_r.data[7:0];
    end
  end

  assign rd_idx   = byte_index(eif.rd_addr, eif.x16);
  assign eif.busy = (eng_r.timer != '0);
  assign eif.rd_data = eif.x16 ? {mem[rd_idx], mem[BW'(rd_idx + 1'h1)]} : {8'h00, mem[rd_idx]};

  // ************************************************************
  // checks
  // ************************************************************
  a_start_busy: assert property (@(posedge clk) disable iff (!resetn)
    (eif.start && !eif.busy) |=> eif.busy)
    else $error("write start did not raise busy");
  a_write_bound: assert property (@(posedge clk) disable iff (!resetn)
    eif.busy |-> eng_r.timer <= TW'(WRITE_CYC))
    else $error("write time exceeds the maximum");
endmodule

/* File: verif/ews_host.sv */
// master model for the three-wire serial pins
`timescale 1ns/1ps
module ews_host (
  // clock
  input wire logic clk,
  // serial pins
  output logic     select_in,
  output logic     shift_clock,
  output logic     serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic last_r = 1'b0;
  logic wire_lvl;

  // no pull on the line: a released output shows the inverse of its last level
  always @(posedge clk) begin
    if (serial_out_oe) begin
      last_r <= serial_out;
    end
  end
  assign wire_lvl = serial_out_oe ? serial_out : ~last_r;

  initial begin
    select_in = 1'b0;
    shift_clock = 1'b0;
    serial_in = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // clock rests low outside frames; each bit is set a full low phase before its rise
  task automatic shift(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = tx[i];
      tick(4);
      rx = {rx[62:0], wire_lvl};
      shift_clock = 1'b1;
      tick(4);
      shift_clock = 1'b0;
    end
  endtask

  task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
    select_in = 1'b1;
    tick(2);
    shift(tx, n, rx);
    tick(2);
    select_in = 1'b0;
    serial_in = 1'b0;
    tick(30);
  endtask

  // select again after a long deselect, then wait for ready under a bound
  task automatic status(input int limit, output logic oe0, output logic lv0, output int waited);
    select_in = 1'b1;
    tick(6);
    oe0 = serial_out_oe;
    lv0 = wire_lvl;
    waited = 0;
    while (wire_lvl !== 1'b1 && waited < limit) begin
      tick(1);
      waited++;
    end
    select_in = 1'b0;
    tick(30);
  endtask
endmodule

/* File: verif/tb.sv */
// self-checking bench for the three-wire serial eeprom port
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
  localparam int WCYC  = 2000;
  localparam int LIMIT = 60000;
  typedef struct packed {
    logic        x16;
    logic [8:0]  a;
    logic [15:0] d;
  } ews_row_s;
  logic        clk;
  logic        resetn;
  logic        select_in;
  logic        shift_clock;
  logic        serial_in;
  logic        serial_out;
  logic        serial_out_oe;
  logic        word_width_strap;
  int          err_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          low_cnt = 0;
  int          oe_bad = 0;
  logic [63:0] rx;
  logic        oe0;
  logic        lv0;
  int          waited;
  ews_row_s    rows [5] = '{{1'b1, 9'h000, 16'ha5c3}, {1'b1, 9'h0ff, 16'h0001}, {1'b1, 9'h07f, 16'h8000},
                            {1'b0, 9'h1ff, 16'h005a}, {1'b0, 9'h000, 16'h00c3}};

  ews_top #(.WRITE_CYC(WCYC)) ews_top_inst (
    .clk(clk), .resetn(resetn), .select_in(select_in), .shift_clock(shift_clock),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .word_width_strap(word_width_strap));
  ews_host ews_host_inst (
    .clk(clk), .select_in(select_in), .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  // ************************************************************
  // clock, watchdog and pin monitor
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    low_cnt = select_in ? 0 : low_cnt + 1;
    if (low_cnt > 4 && serial_out_oe !== 1'b0) begin
      oe_bad++;
    end
    if (cycles == LIMIT) begin
      err_count++;
      report_and_stop();
    end
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic done_test(input string name);
    $display("test %s done", name);
  endtask

  // start bit, opcode, address of the current width, then nd data bits
  task automatic run(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d, input int nd);
    logic [63:0] tx;
    int          na;
    na = word_width_strap ? ews_pkg::ADDR_X16 : ews_pkg::ADDR_X8;
    tx = 64'h1;
    tx = (tx << 2) | 64'(op);
    tx = (tx << na) | 64'(a);
    tx = (tx << nd) | 64'(d);
    ews_host_inst.frame(tx, 3 + na + nd, rx);
  endtask

  task automatic ext(input logic [1:0] code, input logic [15:0] d, input int nd);
    run(ews_pkg::OP_EXT, word_width_strap ? {1'b0, code, 6'h0} : {code, 7'h0}, d, nd);
  endtask

  // every call follows a started write, so busy must show first
  task automatic settle;
    ews_host_inst.status(WCYC + 20, oe0, lv0, waited);
    `CHK(oe0, 1'b1)
    `CHK(lv0, 1'b0)
    `CHK(waited <= WCYC, 1'b1)
  endtask

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    run(ews_pkg::OP_WRITE, a, d, word_width_strap ? 16 : 8);
    settle();
  endtask

  task automatic rd(input logic [8:0] a, input logic [15:0] exp);
    int          nd;
    logic [15:0] got;
    nd = word_width_strap ? 17 : 9;
    run(ews_pkg::OP_READ, a, 16'h0, nd);
    got = word_width_strap ? rx[15:0] : 16'(rx[7:0]);
    `CHK(1'(rx >> (nd - 1)), 1'b0)
    `CHK(got, exp)
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    resetn = 1'b0;
    word_width_strap = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    `CHK(serial_out_oe, 1'b0)
    resetn = 1'b1;
    ews_host_inst.tick(10);
    `CHK(serial_out_oe, 1'b0)
    done_test("reset");

    ext(ews_pkg::EXT_ERASE_WRITE_UNLOCK, 16'h0, 0);
    ext(ews_pkg::EXT_ERAL, 16'h0, 0);
    settle();
    ext(ews_pkg::EXT_LOCK, 16'h0, 0);
    run(ews_pkg::OP_WRITE, 9'h005, 16'h1234, 16);
    ews_host_inst.status(10, oe0, lv0, waited);
    `CHK(oe0, 1'b0)
    rd(9'h005, 16'hffff);
    done_test("locked");

    ext(ews_pkg::EXT_ERASE_WRITE_UNLOCK, 16'h0, 0);
    foreach (rows[i]) begin
      word_width_strap = rows[i].x16;
      ews_host_inst.tick(5);
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].d);
    end
    done_test("rows");

    // one x16 word is two bytes, high byte at the even address
    word_width_strap = 1'b1;
    ews_host_inst.tick(5);
    wr(9'h010, 16'hbeef);
    word_width_strap = 1'b0;
    ews_host_inst.tick(5);
    rd(9'h020, 16'h00be);
    rd(9'h021, 16'h00ef);
    done_test("pairing");

    word_width_strap = 1'b1;
    ews_host_inst.tick(5);
    run(ews_pkg::OP_READ, 9'h010, 16'h0, 33);
    `CHK(rx[32:0], 33'h0_beef_ffff)
    done_test("sequential");

    run(ews_pkg::OP_ERASE, 9'h010, 16'h0, 0);
    settle();
    rd(9'h010, 16'hffff);
    ext(ews_pkg::EXT_WRAL, 16'h3c3c, 16);
    settle();
    rd(9'h0ff, 16'h3c3c);
    rd(9'h000, 16'h3c3c);
    done_test("erase_and_fill");

    // a full write frame sent with select low must change nothing
    ews_host_inst.shift({37'h0, 1'b1, ews_pkg::OP_WRITE, 8'h00, 16'h0000}, 27, rx);
    ews_host_inst.tick(30);
    rd(9'h000, 16'h3c3c);
    `CHK(oe_bad, 0)
    done_test("deselected");

    report_and_stop();
  end
endmodule
